// >>> nvmuc_consts.svh
// register offsets, field positions, reset values and timing counts for the nvm unlock and control block
`ifndef NVMUC_CONSTS_SVH
`define NVMUC_CONSTS_SVH

// ==========================================================================
// register byte offsets on the apb bus
`define NVMUC_OFF_CONTROL   12'h000
`define NVMUC_OFF_KEY       12'h004
`define NVMUC_OFF_ADDR_LO   12'h008
`define NVMUC_OFF_ADDR_HI   12'h00c
`define NVMUC_OFF_DATA_LO   12'h010
`define NVMUC_OFF_DATA_HI   12'h014
`define NVMUC_OFF_IRQ_STAT  12'h018
`define NVMUC_OFF_IRQ_CLR   12'h01c
`define NVMUC_OFF_IRQ_EN    12'h020

// ==========================================================================
// control register bit positions
`define NVMUC_CTL_RD        0
`define NVMUC_CTL_WR        1

// ==========================================================================
// unlock pattern, reset values and read-back fill and mask
`define NVMUC_KEY_FIRST     8'h55
`define NVMUC_KEY_SECOND    8'haa
`define NVMUC_KEY_RST       8'h00
`define NVMUC_ADDR_HI_FILL  8'h80
`define NVMUC_DATA_HI_MASK  8'h3f

// ==========================================================================
// timing: window from second key write to write start, in ns
`define NVMUC_UNLOCK_WIN_NS 200
`define NVMUC_CLK_PERIOD_NS 10
`define NVMUC_UNLOCK_WIN_CYC (`NVMUC_UNLOCK_WIN_NS / `NVMUC_CLK_PERIOD_NS)

// ==========================================================================
// interrupt status bit positions
`define NVMUC_IRQ_RD_DONE   0
`define NVMUC_IRQ_WR_START  1
`define NVMUC_IRQ_WR_REJECT 2
`define NVMUC_IRQ_BITS      3

`endif

// >>> nvmuc_pkg.sv
// types shared by the nvm unlock and control block
package nvmuc_pkg;

  // ==========================================================================
  // unlock sequence states
  typedef enum logic [1:0] {
    NVMUC_LOCKED,
    NVMUC_HALF,
    NVMUC_ARMED
  } nvmuc_unlock_t;

endpackage

// >>> nvmuc_mem_if.sv
// memory port bundle between the control block and its memory
`timescale 1ns/1ps
interface nvmuc_mem_if #(
  parameter int AW = 15,
  parameter int DW = 14
);
  logic          rd_en;
  logic          wr_en;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
  modport mem  (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

// >>> nvmuc_mem.sv
// small memory model standing in for the nonvolatile array
`timescale 1ns/1ps
module nvmuc_mem #(
  parameter int AW    = 15,
  parameter int DW    = 14,
  parameter int DEPTH = 256
) (
  // clock
  input wire logic   clk_i,
  // memory port
  nvmuc_mem_if.mem   mp
);
  localparam int IW = $clog2(DEPTH);

  logic [DW-1:0] store [DEPTH];
  logic [DW-1:0] rdata_q;

  // ==========================================================================
  // read data come out of a register; writes only after a granted start
  always_ff @(posedge clk_i) begin
    if (mp.wr_en) begin
      store[mp.addr[IW-1:0]] <= mp.wdata;
    end
    if (mp.rd_en) begin
      rdata_q <= store[mp.addr[IW-1:0]];
    end
  end

  assign mp.rdata = rdata_q;
endmodule

// >>> nvmuc_top.sv
// apb register front end with unlock key check for the nonvolatile memory
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "nvmuc_consts.svh"
module nvmuc_top import nvmuc_pkg::*; #(
  parameter int DEPTH   = 256,
  parameter int WIN_CYC = `NVMUC_UNLOCK_WIN_CYC
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // interrupt
  output logic             irq_o
);
  // ==========================================================================
  // reset synchroniser
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================================
  // apb decode; one wait state so every answer leaves a flip-flop
  logic       acc;
  logic       wr_acc;
  logic       rd_acc;
  logic       mapped;
  logic [7:0] wbyte;

  assign acc    = psel_i && penable_i && !pready_o;
  assign wr_acc = acc && pwrite_i;
  assign rd_acc = acc && !pwrite_i;
  assign wbyte  = pstrb_i[0] ? pwdata_i[7:0] : 8'h00;

  always_comb begin
    case (paddr_i)
      `NVMUC_OFF_CONTROL, `NVMUC_OFF_KEY, `NVMUC_OFF_ADDR_LO, `NVMUC_OFF_ADDR_HI,
      `NVMUC_OFF_DATA_LO, `NVMUC_OFF_DATA_HI, `NVMUC_OFF_IRQ_STAT, `NVMUC_OFF_IRQ_CLR,
      `NVMUC_OFF_IRQ_EN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  logic wr_ctl;
  logic wr_key;
  logic wr_lane;

  assign wr_lane = wr_acc && mapped && pstrb_i[0];
  assign wr_ctl  = wr_lane && (paddr_i == `NVMUC_OFF_CONTROL);
  assign wr_key  = wr_lane && (paddr_i == `NVMUC_OFF_KEY);

  // ==========================================================================
  // address and data registers
  logic [7:0] addr_lo;
  logic [6:0] addr_hi;
  logic [7:0] data_lo;
  logic [5:0] data_hi;
  logic       rd_pend;

  nvmuc_mem_if #(.AW(15), .DW(14)) mif ();

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_lo <= 8'h00;
      addr_hi <= 7'h00;
    end else if (wr_lane) begin
      if (paddr_i == `NVMUC_OFF_ADDR_LO) begin
        addr_lo <= wbyte;
      end
      if (paddr_i == `NVMUC_OFF_ADDR_HI) begin
        addr_hi <= wbyte[6:0];
      end
    end
  end

  // memory read result lands one cycle after the read strobe
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_lo <= 8'h00;
      data_hi <= 6'h00;
    end else if (rd_pend) begin
      data_lo <= mif.rdata[7:0];
      data_hi <= mif.rdata[13:8];
    end else if (wr_lane) begin
      if (paddr_i == `NVMUC_OFF_DATA_LO) begin
        data_lo <= wbyte;
      end
      if (paddr_i == `NVMUC_OFF_DATA_HI) begin
        data_hi <= wbyte[5:0];
      end
    end
  end

  // ==========================================================================
  // unlock detector; key bytes are compared, never kept
  nvmuc_unlock_t ulk;
  logic [7:0]    win_cnt;
  logic          unlocked;

  assign unlocked = (ulk == NVMUC_ARMED);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ulk     <= NVMUC_LOCKED;
      win_cnt <= 8'h00;
    end else if (wr_key) begin
      case (ulk)
        NVMUC_LOCKED: ulk <= (wbyte == `NVMUC_KEY_FIRST) ? NVMUC_HALF : NVMUC_LOCKED;
        NVMUC_HALF: begin
          ulk     <= (wbyte == `NVMUC_KEY_SECOND) ? NVMUC_ARMED :
                     (wbyte == `NVMUC_KEY_FIRST) ? NVMUC_HALF : NVMUC_LOCKED;
          win_cnt <= 8'(WIN_CYC);
        end
        default: ulk <= (wbyte == `NVMUC_KEY_FIRST) ? NVMUC_HALF : NVMUC_LOCKED;
      endcase
    end else if (wr_acc) begin
      // any other write breaks the sequence
      ulk <= NVMUC_LOCKED;
    end else if (unlocked) begin
      if (win_cnt == 8'h00) begin
        ulk <= NVMUC_LOCKED;
      end else begin
        win_cnt <= win_cnt - 8'h01;
      end
    end
  end

  // ==========================================================================
  // start bits: read start self-clears after one cycle
  logic ctl_rd;
  logic ctl_wr;
  logic wr_grant;
  logic wr_reject;
  logic rd_req;

  assign rd_req    = wr_ctl && wbyte[`NVMUC_CTL_RD];
  assign wr_grant  = wr_ctl && wbyte[`NVMUC_CTL_WR] && unlocked;
  assign wr_reject = wr_ctl && wbyte[`NVMUC_CTL_WR] && !unlocked;

  // set by software, cleared by hardware
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctl_rd  <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      ctl_rd  <= rd_req;
      rd_pend <= rd_req;
    end
  end

  // write start only shows for one cycle; no timing engine behind it
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctl_wr <= 1'b0;
    end else begin
      ctl_wr <= wr_grant;
    end
  end

  assign mif.wr_en = wr_grant;
  assign mif.rd_en = rd_req;
  assign mif.addr  = {addr_hi, addr_lo};
  assign mif.wdata = {data_hi, data_lo};

  nvmuc_mem #(.AW(15), .DW(14), .DEPTH(DEPTH)) u_mem (
    .clk_i (ref_clk_i),
    .mp    (mif.mem)
  );

  // ==========================================================================
  // interrupt status, enable and clear; set wins over clear
  logic [`NVMUC_IRQ_BITS-1:0] irq_stat;
  logic [`NVMUC_IRQ_BITS-1:0] irq_en;
  logic [`NVMUC_IRQ_BITS-1:0] irq_evt;
  logic [`NVMUC_IRQ_BITS-1:0] irq_clr;

  assign irq_evt = {wr_reject, wr_grant, rd_pend};
  assign irq_clr = (wr_lane && paddr_i == `NVMUC_OFF_IRQ_CLR) ? wbyte[`NVMUC_IRQ_BITS-1:0] : '0;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq_en   <= '0;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
      if (wr_lane && paddr_i == `NVMUC_OFF_IRQ_EN) begin
        irq_en <= wbyte[`NVMUC_IRQ_BITS-1:0];
      end
      irq_o <= |(((irq_stat & ~irq_clr) | irq_evt) & irq_en);
    end
  end

  // ==========================================================================
  // read mux
  logic [7:0] rmux;

  always_comb begin
    rmux = 8'h00;
    case (paddr_i)
      `NVMUC_OFF_CONTROL:  rmux = {6'h00, ctl_wr, ctl_rd};
      `NVMUC_OFF_ADDR_HI:  rmux = `NVMUC_ADDR_HI_FILL | {1'b0, addr_hi};
      `NVMUC_OFF_ADDR_LO:  rmux = addr_lo;
      `NVMUC_OFF_DATA_LO:  rmux = data_lo;
      `NVMUC_OFF_DATA_HI:  rmux = {2'b00, data_hi} & `NVMUC_DATA_HI_MASK;
      `NVMUC_OFF_IRQ_STAT: rmux = {5'h00, irq_stat};
      `NVMUC_OFF_IRQ_EN:   rmux = {5'h00, irq_en};
      default:             rmux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= acc;
      pslverr_o <= acc && !mapped;
      prdata_o  <= rd_acc ? {24'h00_0000, rmux} : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // checks
  // armed age helper
  // counted apart from win_cnt so a wrong reload of the window shows up
  logic [8:0] armed_age;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      armed_age <= 9'h000;
    end else if (!unlocked || wr_key) begin
      armed_age <= 9'h000;
    end else begin
      armed_age <= armed_age + 9'h001;
    end
  end

  a_addr_hi_msb: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (pready_o && rd_acc == 1'b0 && $past(rd_acc) && $past(paddr_i) == `NVMUC_OFF_ADDR_HI) |-> prdata_o[7])
    else $error("address high msb did not read one");

  a_data_hi_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ($past(rd_acc) && $past(paddr_i) == `NVMUC_OFF_DATA_HI) |-> prdata_o[31:6] == '0)
    else $error("data high upper bits not zero");

  a_rd_selfclr: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ctl_rd |=> !ctl_rd)
    else $error("read start not cleared after one cycle");

  sequence s_read_steps;
    rd_pend ##1 ({data_hi, data_lo} == $past(mif.rdata));
  endsequence

  a_rd_loads: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    rd_req |=> s_read_steps)
    else $error("read result not loaded in time");

  sequence s_key_pair;
    (wr_key && wbyte == `NVMUC_KEY_FIRST) ##1 (!wr_acc)[*3] ##1 (wr_key && wbyte == `NVMUC_KEY_SECOND);
  endsequence

  a_unlock_arms: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (ulk == NVMUC_HALF && wr_key && wbyte == `NVMUC_KEY_SECOND) |=> unlocked)
    else $error("unlock pattern did not arm write");

  a_key_pair_seen: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    s_key_pair |=> unlocked)
    else $error("key pair did not unlock");

  a_no_lock_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    mif.wr_en |-> unlocked)
    else $error("memory written while locked");

  a_reject_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    wr_reject |=> irq_stat[`NVMUC_IRQ_WR_REJECT] && !ctl_wr)
    else $error("refused write start not flagged");

  a_key_relocks: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (wr_acc && !wr_key) |=> !unlocked)
    else $error("unlock survived another write");

  a_win_expiry: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (unlocked && win_cnt == 8'h00 && !wr_acc) |=> !unlocked)
    else $error("unlock outlived its window");

  a_win_bound: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    unlocked |-> armed_age <= 9'(WIN_CYC))
    else $error("unlock held past its window");

  // irq lags a change of enable by one cycle
  a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ##1 irq_o == |(irq_stat & $past(irq_en)))
    else $error("interrupt output wrong");

  a_key_no_store: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ($past(rd_acc) && $past(paddr_i) == `NVMUC_OFF_KEY) |-> prdata_o == '0)
    else $error("key port read back data");

  a_key_regs_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    wr_key |=> $stable(addr_lo) && $stable(addr_hi) && $stable(data_lo) && $stable(data_hi))
    else $error("key write altered a register");

  a_ready_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    pready_o |=> !pready_o)
    else $error("ready stood longer than one cycle");

  a_unmapped_err: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (acc && !mapped) |=> pslverr_o && pready_o)
    else $error("unmapped access not answered with error");
endmodule

// >>> testbench.sv
// self-checking apb testbench for the nvm unlock and control block
`timescale 1ns/1ps
`include "nvmuc_consts.svh"
module testbench;
  localparam int          WIN = 20;
  localparam logic [11:0] CT  = `NVMUC_OFF_CONTROL;
  localparam logic [11:0] KY  = `NVMUC_OFF_KEY;
  localparam logic [11:0] AL  = `NVMUC_OFF_ADDR_LO;
  localparam logic [11:0] AH  = `NVMUC_OFF_ADDR_HI;
  localparam logic [11:0] DL  = `NVMUC_OFF_DATA_LO;
  localparam logic [11:0] DH  = `NVMUC_OFF_DATA_HI;
  localparam logic [11:0] ST  = `NVMUC_OFF_IRQ_STAT;
  localparam logic [11:0] CL  = `NVMUC_OFF_IRQ_CLR;
  localparam logic [11:0] EN  = `NVMUC_OFF_IRQ_EN;
  logic        ref_clk_i;
  logic        nrst_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0]  pstrb_i;
  logic        pready_o;
  logic [31:0] prdata_o;
  logic        pslverr_o;
  logic        irq_o;
  int          n_fail;
  int          checks_done;
  logic [32:0] exp_q[$];
  bit          chk_q[$];
  string       name_q[$];
  logic [7:0]  alo;
  logic [7:0]  dlo;
  logic [7:0]  dhi;

  nvmuc_top #(.WIN_CYC(WIN)) dut (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .pstrb_i   (pstrb_i),
    .pready_o  (pready_o),
    .prdata_o  (prdata_o),
    .pslverr_o (pslverr_o),
    .irq_o     (irq_o)
  );

  // ==========================================================================
  // clock and watchdog
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // whole run is a few hundred cycles; a hang stops here
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    test_done();
  end

  // ==========================================================================
  // checking
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // pready stands one cycle; the answer is taken at the rising edge that samples it high
  always @(posedge ref_clk_i) begin : mon
    logic [32:0] e;
    if (pready_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp("unexpected answer", 32'h0, 32'h1);
      end else begin
        e = exp_q.pop_front();
        cmp({name_q[0], " error"}, {31'h0, e[32]}, {31'h0, pslverr_o});
        if (chk_q.pop_front()) cmp(name_q[0], e[31:0], prdata_o);
        void'(name_q.pop_front());
      end
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask

  // ==========================================================================
  // apb master: request held until the edge where pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e,
                     input bit c, input string nm);
    int n;
    exp_q.push_back(e);
    chk_q.push_back(c);
    name_q.push_back(nm);
    @(posedge ref_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= {24'h0, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) cmp("pready", 32'h1, 32'h0);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0, 1'b0, "write");
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00, {25'h0, e}, 1'b1, nm);
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(negedge ref_clk_i);
    cmp("irq", {31'h0, e}, {31'h0, irq_o});
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    nrst_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
    paddr_i = 12'h000; pwdata_i = 32'h0; pstrb_i = 4'hf;
    n_fail = 0; checks_done = 0;
    void'($urandom(56));
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rd(CT, 8'h00, "control");
    rd(KY, 8'h00, "key");
    rd(AH, 8'h80, "addr high");
    rd(DH, 8'h00, "data high");
    rd(ST, 8'h00, "status");
    irq_is(1'b0);
    tend("reset values");
    wr(AH, 8'hff);
    rd(AH, 8'hff, "addr high");
    wr(AH, 8'h00);
    rd(AH, 8'h80, "addr high");
    wr(DH, 8'hff);
    rd(DH, 8'h3f, "data high");
    wr(KY, 8'hff);
    rd(KY, 8'h00, "key");
    apb(1'b0, 12'h024, 8'h00, {1'b1, 32'h0}, 1'b1, "unmapped");
    apb(1'b1, 12'h024, 8'h5a, {1'b1, 32'h0}, 1'b0, "unmapped");
    tend("fields");
    alo = 8'($urandom);
    dlo = 8'($urandom);
    dhi = 8'($urandom) & 8'h3f;
    wr(AL, alo); wr(DL, dlo); wr(DH, dhi); wr(CL, 8'h07);
    wr(KY, 8'h55); wr(KY, 8'haa);
    rd(KY, 8'h00, "key");
    wr(CT, 8'h02);
    rd(ST, 8'h02, "status");
    wr(DL, ~dlo); wr(DH, 8'h00); wr(CL, 8'h07);
    wr(CT, 8'h01);
    rd(CT, 8'h00, "control");
    rd(DL, dlo, "data low");
    rd(DH, dhi, "data high");
    rd(ST, 8'h01, "status");
    tend("unlocked write");
    // every broken unlock must be refused and leave the stored word alone
    for (int k = 0; k < 6; k++) begin
      wr(DL, ~dlo); wr(DH, ~dhi & 8'h3f); wr(CL, 8'h07);
      case (k)
        1: begin wr(KY, 8'haa); wr(KY, 8'h55); end
        2: begin wr(KY, 8'h55); wr(KY, 8'haa); wr(AL, alo); end
        3: begin wr(KY, 8'h55); wr(KY, 8'haa); repeat (WIN + 5) @(posedge ref_clk_i); end
        4: wr(KY, 8'h55);
        5: begin
          wr(KY, 8'h55);
          wr(KY, 8'haa);
          pstrb_i <= 4'he;
          wr(AL, ~alo);
          pstrb_i <= 4'hf;
        end
        default: ;
      endcase
      wr(CT, 8'h02);
      rd(ST, 8'h04, "status");
      wr(CT, 8'h01);
      rd(DL, dlo, "data low");
      rd(DH, dhi, "data high");
    end
    tend("refused writes");
    wr(CL, 8'h07); wr(EN, 8'h04);
    rd(EN, 8'h04, "irq enable");
    wr(CT, 8'h02);
    irq_is(1'b1);
    wr(CL, 8'h04);
    irq_is(1'b0);
    rd(ST, 8'h00, "status");
    wr(EN, 8'h01); wr(CT, 8'h02);
    irq_is(1'b0);
    rd(ST, 8'h04, "status");
    tend("interrupt");
    // a reset between the key pair and write start must drop the unlock
    wr(KY, 8'h55);
    wr(KY, 8'haa);
    nrst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rd(AL, 8'h00, "addr low");
    wr(CT, 8'h02);
    rd(ST, 8'h04, "status");
    irq_is(1'b0);
    tend("reset mid run");
    repeat (5) @(posedge ref_clk_i);
    test_done();
  end
endmodule
